// ==== rtl/phy_status_pkg.sv ====
// Contract
// - Next-page code bits 10:0 read-write, reset to null page value one.
// - Flag bit 13 set sends code as message page, else unformatted page.
// - Summary bit 15 ignores writes and always reads zero.
// - Summary bit 14 is crossover: one means pairs swapped, zero normal.
// - Crossover follows enable and force; live if enabled but not forced.
// - Summary bit 13 latches receive errors until error counter is read.
// - Bit 12 mirrors polarity bit 4; only a 10 Mb/s status read clears it.
// - Summary bit 11 latches false carrier until its counter is read.
// - Bit 10 is raw detect, ANDed with lock when control bit 8 set.
// - Qualified detect bit is read-only latch-low until summary read.
// - Bit 9 is descrambler lock, read-only latch-low until read.
// - Latch-high bits never drop by themselves before the clearing read.
// - Status summary register sits at management offset 10h.
package phy_status_pkg;
	localparam int IDX_W = 6;
	localparam logic [IDX_W-1:0] IDX_NEXT_PAGE      = 6'h07;
	localparam logic [IDX_W-1:0] IDX_SUMMARY        = 6'h10;
	localparam logic [IDX_W-1:0] IDX_FALSE_CARRIER  = 6'h14;
	localparam logic [IDX_W-1:0] IDX_RX_ERROR       = 6'h15;
	localparam logic [IDX_W-1:0] IDX_PCS_CONFIG     = 6'h16;
	localparam logic [IDX_W-1:0] IDX_PHY_CONTROL    = 6'h19;
	localparam logic [IDX_W-1:0] IDX_TENMEG         = 6'h1A;
	localparam logic [IDX_W-1:0] IDX_INT_STATUS     = 6'h20;
	localparam logic [IDX_W-1:0] IDX_INT_CLEAR      = 6'h21;
	localparam logic [IDX_W-1:0] IDX_INT_ENABLE     = 6'h22;
	localparam int ADDR_LSB = 2;

	localparam int NP_NEXT   = 15;
	localparam int NP_MP     = 13;
	localparam int NP_ACK2   = 12;
	localparam int NP_TOGGLE = 11;
	localparam int CODE_W    = 11;
	localparam logic [CODE_W-1:0] CODE_NULL_PAGE = 11'h001;
	localparam logic MP_RESET = 1'h1;

	localparam int SUM_XOVER = 14;
	localparam int SUM_RXERR = 13;
	localparam int SUM_POL   = 12;
	localparam int SUM_FC    = 11;
	localparam int SUM_SD    = 10;
	localparam int SUM_LOCK  = 9;

	localparam int PCS_SD_QUAL       = 8;
	localparam int PHY_XOVER_EN      = 15;
	localparam int PHY_XOVER_FORCE   = 14;
	localparam logic XOVER_EN_RESET  = 1'h1;
	localparam int TENMEG_POL        = 4;

	localparam int IRQ_W        = 4;
	localparam int IRQ_RXERR    = 0;
	localparam int IRQ_FC       = 1;
	localparam int IRQ_SD_LOSS  = 2;
	localparam int IRQ_LOCK_LOSS = 3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// ==== rtl/phy_status_summary_regs.sv ====
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ns
module phy_status_summary_regs #(
	parameter int ADDR_W = 8,
	parameter int CNT_W  = 16
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              rx_error_event,
	input  wire logic              false_carrier_event,
	input  wire logic              polarity_inverted_event,
	input  wire logic              signal_detect_raw,
	input  wire logic              descrambler_lock,
	input  wire logic              crossover_swapped,
	input  wire logic              link_toggle,
	input  wire logic [CNT_W-1:0]  rx_error_count_field,
	input  wire logic [CNT_W-1:0]  false_carrier_count,
	output logic [15:0]            next_page_word,
	output logic                   next_page_is_message,
	output logic                   crossover_auto_enable,
	output logic                   crossover_force,
	output logic                   irq
);
	typedef struct packed {
		logic                                aw_got;
		logic                                w_got;
		logic [phy_status_pkg::IDX_W-1:0]    aw_idx;
		logic [31:0]                         wdata;
		logic [3:0]                          wstrb;
		logic                                bvalid;
		logic [1:0]                          bresp;
		logic                                rvalid;
		logic [31:0]                         rdata;
		logic [1:0]                          rresp;
		logic                                np_next;
		logic                                message_page_flag;
		logic                                np_ack2;
		logic [phy_status_pkg::CODE_W-1:0]   np_code;
		logic                                sd_qualify;
		logic                                xover_en;
		logic                                xover_force;
		logic                                rx_err_latch;
		logic                                fc_latch;
		logic                                pol_latch;
		logic                                sd_ll;
		logic                                lock_ll;
		logic [phy_status_pkg::IRQ_W-1:0]    int_status;
		logic [phy_status_pkg::IRQ_W-1:0]    int_enable;
	} state_s;

	state_s s;
	state_s next_s;

	logic        sd_qualified;
	logic        xover_state;
	logic [15:0] summary_word;
	logic        rd_fire;
	logic        wr_do;
	logic [phy_status_pkg::IDX_W-1:0] rd_idx;

	// Applies the low two byte strobes to a 16-bit register image
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] st);
		logic [15:0] r;
		r = old;
		if (st[0]) begin
			r[7:0] = wd[7:0];
		end
		if (st[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction

	function automatic logic [phy_status_pkg::IDX_W-1:0] word_index(
		input logic [ADDR_W-1:0] a);
		return a[phy_status_pkg::ADDR_LSB +: phy_status_pkg::IDX_W];
	endfunction

	// Qualified detect and crossover state, both live
	assign sd_qualified = s.sd_qualify ? (signal_detect_raw & descrambler_lock)
		: signal_detect_raw;
	assign xover_state = s.xover_force
		| (s.xover_en & crossover_swapped);

	always_comb begin
		summary_word = '0;
		summary_word[phy_status_pkg::SUM_XOVER] = xover_state;
		summary_word[phy_status_pkg::SUM_RXERR] = s.rx_err_latch;
		summary_word[phy_status_pkg::SUM_POL]   = s.pol_latch;
		summary_word[phy_status_pkg::SUM_FC]    = s.fc_latch;
		summary_word[phy_status_pkg::SUM_SD]    = s.sd_ll;
		summary_word[phy_status_pkg::SUM_LOCK]  = s.lock_ll;
	end

	assign s_axi_awready = !s.aw_got && !s.bvalid;
	assign s_axi_wready  = !s.w_got && !s.bvalid;
	assign s_axi_arready = !s.rvalid;
	assign rd_fire       = s_axi_arvalid && s_axi_arready;
	assign rd_idx        = word_index(s_axi_araddr);
	assign wr_do         = s.aw_got && s.w_got && !s.bvalid;

	always_comb begin
		logic [15:0] img;
		logic [15:0] rd_word;
		logic        rd_ok;
		logic        rd_summary;
		logic        rd_fc;
		logic        rd_rx;
		logic        rd_tenmeg;
		logic [phy_status_pkg::IRQ_W-1:0] ev;
		logic [phy_status_pkg::IRQ_W-1:0] clr;
		img        = '0;
		rd_word    = '0;
		rd_ok      = 1'b1;
		clr        = '0;
		ev         = '0;
		next_s     = s;
		rd_summary = rd_fire && rd_idx == phy_status_pkg::IDX_SUMMARY;
		rd_fc      = rd_fire && rd_idx == phy_status_pkg::IDX_FALSE_CARRIER;
		rd_rx      = rd_fire && rd_idx == phy_status_pkg::IDX_RX_ERROR;
		rd_tenmeg  = rd_fire && rd_idx == phy_status_pkg::IDX_TENMEG;

		if (s_axi_awvalid && s_axi_awready) begin
			next_s.aw_got = 1'b1;
			next_s.aw_idx = word_index(s_axi_awaddr);
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_s.w_got = 1'b1;
			next_s.wdata = s_axi_wdata;
			next_s.wstrb = s_axi_wstrb;
		end
		if (wr_do) begin
			next_s.aw_got = 1'b0;
			next_s.w_got  = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp  = phy_status_pkg::RESP_OKAY;
			unique case (s.aw_idx)
				phy_status_pkg::IDX_NEXT_PAGE: begin
					img = merge16(next_page_word, s.wdata, s.wstrb);
					next_s.np_next = img[phy_status_pkg::NP_NEXT];
					next_s.message_page_flag = img[phy_status_pkg::NP_MP];
					next_s.np_ack2 = img[phy_status_pkg::NP_ACK2];
					next_s.np_code = img[phy_status_pkg::CODE_W-1:0];
				end
				phy_status_pkg::IDX_PCS_CONFIG: begin
					img = merge16('0, s.wdata, s.wstrb);
					if (s.wstrb[1]) begin
						next_s.sd_qualify = img[phy_status_pkg::PCS_SD_QUAL];
					end
				end
				phy_status_pkg::IDX_PHY_CONTROL: begin
					img = merge16('0, s.wdata, s.wstrb);
					if (s.wstrb[1]) begin
						next_s.xover_en = img[phy_status_pkg::PHY_XOVER_EN];
						next_s.xover_force = img[phy_status_pkg::PHY_XOVER_FORCE];
					end
				end
				phy_status_pkg::IDX_INT_CLEAR: begin
					if (s.wstrb[0]) begin
						clr = s.wdata[phy_status_pkg::IRQ_W-1:0];
					end
				end
				phy_status_pkg::IDX_INT_ENABLE: begin
					if (s.wstrb[0]) begin
						next_s.int_enable = s.wdata[phy_status_pkg::IRQ_W-1:0];
					end
				end
				// Read-only registers, the summary among them, ignore writes
				phy_status_pkg::IDX_SUMMARY, phy_status_pkg::IDX_FALSE_CARRIER,
				phy_status_pkg::IDX_RX_ERROR, phy_status_pkg::IDX_TENMEG,
				phy_status_pkg::IDX_INT_STATUS: begin
					next_s.bresp = phy_status_pkg::RESP_OKAY;
				end
				default: begin
					next_s.bresp = phy_status_pkg::RESP_DECERR;
				end
			endcase
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end

		unique case (rd_idx)
			phy_status_pkg::IDX_NEXT_PAGE:     rd_word = next_page_word;
			phy_status_pkg::IDX_SUMMARY:       rd_word = summary_word;
			phy_status_pkg::IDX_FALSE_CARRIER: rd_word = 16'(false_carrier_count);
			phy_status_pkg::IDX_RX_ERROR:      rd_word = 16'(rx_error_count_field);
			phy_status_pkg::IDX_PCS_CONFIG: begin
				rd_word[phy_status_pkg::PCS_SD_QUAL] = s.sd_qualify;
			end
			phy_status_pkg::IDX_PHY_CONTROL: begin
				rd_word[phy_status_pkg::PHY_XOVER_EN] = s.xover_en;
				rd_word[phy_status_pkg::PHY_XOVER_FORCE] = s.xover_force;
			end
			phy_status_pkg::IDX_TENMEG: begin
				rd_word[phy_status_pkg::TENMEG_POL] = s.pol_latch;
			end
			phy_status_pkg::IDX_INT_STATUS: rd_word = 16'(s.int_status);
			phy_status_pkg::IDX_INT_ENABLE: rd_word = 16'(s.int_enable);
			phy_status_pkg::IDX_INT_CLEAR:  rd_word = '0;
			default: rd_ok = 1'b0;
		endcase
		if (rd_fire) begin
			next_s.rvalid = 1'b1;
			next_s.rdata  = {16'h0000, rd_word};
			next_s.rresp  = rd_ok ? phy_status_pkg::RESP_OKAY
				: phy_status_pkg::RESP_DECERR;
		end else if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end

		// Events win over a clearing read in the same cycle
		next_s.rx_err_latch = rx_error_event
			| (s.rx_err_latch & !rd_rx);
		next_s.fc_latch = false_carrier_event
			| (s.fc_latch & !rd_fc);
		next_s.pol_latch = polarity_inverted_event
			| (s.pol_latch & !rd_tenmeg);
		// A read reloads the live level; a drop in the read cycle still shows
		next_s.sd_ll = rd_summary ? sd_qualified
			: (s.sd_ll & sd_qualified);
		next_s.lock_ll = rd_summary ? descrambler_lock
			: (s.lock_ll & descrambler_lock);

		ev[phy_status_pkg::IRQ_RXERR]     = rx_error_event;
		ev[phy_status_pkg::IRQ_FC]        = false_carrier_event;
		ev[phy_status_pkg::IRQ_SD_LOSS]   = s.sd_ll & !sd_qualified;
		ev[phy_status_pkg::IRQ_LOCK_LOSS] = s.lock_ll & !descrambler_lock;
		next_s.int_status = ev | (s.int_status & ~clr);

		if (!aresetn) begin
			next_s = '0;
			next_s.message_page_flag = phy_status_pkg::MP_RESET;
			next_s.np_code  = phy_status_pkg::CODE_NULL_PAGE;
			next_s.xover_en = phy_status_pkg::XOVER_EN_RESET;
		end
	end

	always_ff @(posedge aclk) begin
		s <= next_s;
	end

	always_comb begin
		next_page_word = '0;
		next_page_word[phy_status_pkg::NP_NEXT]   = s.np_next;
		next_page_word[phy_status_pkg::NP_MP]     = s.message_page_flag;
		next_page_word[phy_status_pkg::NP_ACK2]   = s.np_ack2;
		next_page_word[phy_status_pkg::NP_TOGGLE] = link_toggle;
		next_page_word[phy_status_pkg::CODE_W-1:0] = s.np_code;
	end

	assign next_page_is_message  = s.message_page_flag;
	assign crossover_auto_enable = s.xover_en;
	assign crossover_force       = s.xover_force;
	assign irq                   = |(s.int_status & s.int_enable);
	assign s_axi_bvalid          = s.bvalid;
	assign s_axi_bresp           = s.bresp;
	assign s_axi_rvalid          = s.rvalid;
	assign s_axi_rdata           = s.rdata;
	assign s_axi_rresp           = s.rresp;

	chk_code_null_reset: assert property (@(posedge aclk)
		!aresetn |=> s.np_code == phy_status_pkg::CODE_NULL_PAGE)
		else $error("code field not null page after reset");
	chk_message_page_out: assert property (@(posedge aclk)
		disable iff (!aresetn)
		wr_do && s.aw_idx == phy_status_pkg::IDX_NEXT_PAGE && s.wstrb[1]
		|=> next_page_is_message == $past(s.wdata[phy_status_pkg::NP_MP]))
		else $error("message page output differs from written flag");
	chk_reserved_zero: assert property (@(posedge aclk)
		disable iff (!aresetn) rd_fire && rd_idx == phy_status_pkg::IDX_SUMMARY
		|=> s_axi_rvalid && s_axi_rdata[15] == 1'b0)
		else $error("reserved summary bit read nonzero");
	chk_xover_forced: assert property (@(posedge aclk)
		disable iff (!aresetn)
		s.xover_force |-> summary_word[phy_status_pkg::SUM_XOVER])
		else $error("forced crossover not reported");
	chk_rx_err_hold: assert property (@(posedge aclk)
		disable iff (!aresetn) s.rx_err_latch && !rd_fire |=> s.rx_err_latch)
		else $error("receive error latch dropped without read");
	chk_fc_set: assert property (@(posedge aclk)
		disable iff (!aresetn) false_carrier_event |=> s.fc_latch[*2]
		or ##1 $past(rd_fire))
		else $error("false carrier latch not set");
	chk_sd_latch_low: assert property (@(posedge aclk)
		disable iff (!aresetn)
		!sd_qualified |=> !summary_word[phy_status_pkg::SUM_SD])
		else $error("signal detect loss not latched");
	chk_lock_reload: assert property (@(posedge aclk)
		disable iff (!aresetn)
		rd_fire && rd_idx == phy_status_pkg::IDX_SUMMARY && descrambler_lock
		|=> s.lock_ll)
		else $error("lock bit not reloaded after read");
	chk_write_answer: assert property (@(posedge aclk)
		disable iff (!aresetn) wr_do |=> s_axi_bvalid)
		else $error("write not answered");
endmodule

// ==== testbench/axil_master.sv ====
`timescale 1ns/1ns
module axil_master (
	input  wire logic        aclk,
	output logic [7:0]       awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	output logic [7:0]       araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end

	// Handshakes are judged at the rising edge, on values from before it
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			output logic [1:0] r, output bit ok);
		ok = 0;
		r = 2'h0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (int n = 0; n < 50 && !ok; n++) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				awvalid <= 1'h0;
			end
			if (wvalid && wready) begin
				wvalid <= 1'h0;
			end
			if (bready && bvalid) begin
				r = bresp;
				ok = 1;
				bready <= 1'h0;
			end
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
			output logic [1:0] r, output bit ok);
		ok = 0;
		d = 32'h0;
		r = 2'h0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (int n = 0; n < 50 && !ok; n++) begin
			@(posedge aclk);
			if (arvalid && arready) begin
				arvalid <= 1'h0;
			end
			if (rready && rvalid) begin
				d = rdata;
				r = rresp;
				ok = 1;
				rready <= 1'h0;
			end
		end
	endtask
endmodule

// ==== testbench/phy_status_summary_regs_bench.sv ====
`timescale 1ns/1ns
module phy_status_summary_regs_bench;
	localparam logic [1:0] OK = phy_status_pkg::RESP_OKAY;
	localparam logic [1:0] DE = phy_status_pkg::RESP_DECERR;
	logic        aclk, aresetn, sd, lock, swapped, irq;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, is_msg, x_en, x_force;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [2:0]  ev;
	logic [15:0] np_word;
	int          fails, check_count;

	axil_master m (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	phy_status_summary_regs dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.rx_error_event(ev[0]), .false_carrier_event(ev[1]),
		.polarity_inverted_event(ev[2]), .signal_detect_raw(sd),
		.descrambler_lock(lock), .crossover_swapped(swapped),
		.link_toggle(1'h0), .rx_error_count_field(16'h0012),
		.false_carrier_count(16'h0033), .next_page_word(np_word),
		.next_page_is_message(is_msg), .crossover_auto_enable(x_en),
		.crossover_force(x_force), .irq(irq));

	always #5 aclk = ~aclk;

	task automatic end_of_test;
		if (fails == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// A hung handshake counts as a mismatch and ends the run
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] er);
		logic [1:0] r;
		bit ok;
		m.wr(a, d, r, ok);
		if (!ok) begin
			fails++;
			end_of_test();
		end
		check("bresp", {30'h0, r}, {30'h0, er});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, mask,
			input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		bit ok;
		m.rd(a, d, r, ok);
		if (!ok) begin
			fails++;
			end_of_test();
		end
		check("rdata", d & mask, exp);
		check("rresp", {30'h0, r}, {30'h0, er});
	endtask

	task automatic pulse(input logic [2:0] v);
		@(posedge aclk);
		ev <= v;
		@(posedge aclk);
		ev <= 3'h0;
		#1;
	endtask

	// Source drops for two cycles, then recovers before the read
	task automatic drop(input bit sd_drop);
		@(posedge aclk);
		if (sd_drop) sd <= 1'h0;
		else lock <= 1'h0;
		repeat (2) @(posedge aclk);
		sd <= 1'h1;
		lock <= 1'h1;
	endtask

	task automatic t_reset;
		rd(8'h1C, 32'h2001, 32'hFFFFFFFF, OK);
		check("np_word", {16'h0, np_word}, 32'h2001);
		check("is_msg", {31'h0, is_msg}, 32'h1);
		rd(8'h40, 32'h0, 32'hFFFF, OK);
		rd(8'h40, 32'h600, 32'hFFFF, OK);
	endtask

	task automatic t_code;
		wr(8'h1C, 32'hFFFF9FFF, OK);
		rd(8'h1C, 32'h97FF, 32'hFFFFFFFF, OK);
		check("is_msg", {31'h0, is_msg}, 32'h0);
		check("np_word", {16'h0, np_word}, 32'h97FF);
		wr(8'h40, 32'hFFFF, OK);
		rd(8'h40, 32'h0, 32'h8000, OK);
		wr(8'hFC, 32'h1, DE);
		rd(8'hFC, 32'h0, 32'hFFFFFFFF, DE);
	endtask

	task automatic t_xover;
		logic [2:0] c;
		for (int k = 0; k < 8; k++) begin
			c = k[2:0];
			@(posedge aclk);
			swapped <= c[0];
			wr(8'h64, {16'h0, c[2:1], 14'h0}, OK);
			check("x_en", {30'h0, x_en, x_force}, {30'h0, c[2:1]});
			rd(8'h40, {17'h0, c[1] | (c[2] & c[0]), 14'h0}, 32'h4000,
				OK);
		end
		wr(8'h64, 32'h8000, OK);
		@(posedge aclk);
		swapped <= 1'h0;
	endtask

	task automatic t_latch;
		logic [31:0] bm;
		for (int i = 0; i < 2; i++) begin
			bm = i ? 32'h800 : 32'h2000;
			wr(8'h88, 32'h0, OK);
			pulse(3'h1 << i);
			check("irq", {31'h0, irq}, 32'h0);
			wr(8'h88, 32'h1 << i, OK);
			check("irq", {31'h0, irq}, 32'h1);
			rd(8'h80, 32'h1 << i, 32'hF, OK);
			rd(8'h40, bm, bm, OK);
			rd(8'h40, bm, bm, OK);
			rd(i ? 8'h50 : 8'h54, i ? 32'h33 : 32'h12, 32'hFFFF, OK);
			rd(8'h40, 32'h0, bm, OK);
			wr(8'h84, 32'h1 << i, OK);
			check("irq", {31'h0, irq}, 32'h0);
		end
	endtask

	task automatic t_pol;
		pulse(3'h4);
		rd(8'h40, 32'h1000, 32'h1000, OK);
		rd(8'h40, 32'h1000, 32'h1000, OK);
		rd(8'h68, 32'h10, 32'h10, OK);
		rd(8'h40, 32'h0, 32'h1000, OK);
	endtask

	task automatic t_sd;
		drop(1'h0);
		rd(8'h40, 32'h400, 32'h600, OK);
		rd(8'h40, 32'h600, 32'h600, OK);
		drop(1'h1);
		rd(8'h40, 32'h200, 32'h600, OK);
		rd(8'h40, 32'h600, 32'h600, OK);
		@(posedge aclk);
		lock <= 1'h0;
		rd(8'h40, 32'h400, 32'h600, OK);
		rd(8'h40, 32'h400, 32'h600, OK);
		wr(8'h58, 32'h100, OK);
		rd(8'h58, 32'h100, 32'hFFFF, OK);
		rd(8'h40, 32'h0, 32'h600, OK);
		rd(8'h40, 32'h0, 32'h600, OK);
	endtask

	initial begin
		aclk = 0;
		aresetn = 0;
		ev = 3'h0;
		sd = 1;
		lock = 1;
		swapped = 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		t_reset();
		t_code();
		t_xover();
		t_latch();
		t_pol();
		t_sd();
		end_of_test();
	end
endmodule
